// ===== design/cmb_buffers.sv
// CAN message buffers: three transmit, one receive, APB window, stamping.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps

// Two-entry buffer; a stalled reader back-pressures the writer.
module cmb_fifo2 #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_r [2];
  logic             wp_r;
  logic             rp_r;
  logic [1:0]       cnt_r;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // Full and empty follow the occupancy count exactly.
  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];

  // Storage is written only on a push and needs no reset.
  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end

  // Pointers and count.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      if (push)
        wp_r <= ~wp_r;
      if (pop)
        rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

module cmb_buffers
  import cmb_pkg::*;
#(
  parameter int NUM_TX   = 3,
  parameter int BIT_DIV  = cmb_pkg::BIT_CYCLES,
  parameter int TS_WIDTH = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        sof_req,
  output logic             tx_start,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [7:0]       tx_data,
  input  wire logic        tx_done,
  input  wire logic        tx_abandon,
  input  wire logic        rx_wr,
  input  wire logic [3:0]  rx_slot,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_eof
);
  import cmb_pkg::*;

  // Refused at elaboration: decode and divider are sized for these.
  if (NUM_TX != 3 || TS_WIDTH != 16 || BIT_DIV < 1 || BIT_DIV > 65536)
  begin
    $error("cmb_buffers: unsupported parameter values");
  end

  localparam int RXB = NUM_TX;

  logic [7:0]          mem_r [NUM_TX+1][NUM_SLOTS];
  logic [1:0]          ctrl_r;
  logic [NUM_TX-1:0]   txe_r;
  logic                rxf_r;
  logic [1:0]          sel_r;
  logic [TS_WIDTH-1:0] timer_r;
  logic [15:0]         div_r;
  logic [1:0]          act_r;
  logic [3:0]          pos_r;
  cmb_txs_t            st_r;

  // Bus decode: setup cycle of a transfer, window slot and buffer.
  wire        setup    = psel & ~penable;
  wire        in_win   = (paddr[6] == 1'b0);
  wire [3:0]  slot     = paddr[5:2];
  wire        slot_ok  = in_win & (slot < 4'(NUM_SLOTS));
  wire        rx_win   = paddr[7];
  wire [1:0]  wbuf     = rx_win ? 2'(RXB) : sel_r;
  wire        sel_free = rx_win | txe_r[sel_r];
  wire        is_ctrl  = (paddr == OFS_CTRL);
  wire        is_flag  = (paddr == OFS_TXFLAG);
  wire        is_sel   = (paddr == OFS_TXSEL);
  wire        is_tmr   = (paddr == OFS_TIMER);
  wire        mapped   = slot_ok | is_ctrl | is_flag | is_sel | is_tmr;
  wire        ts_slot  = (slot == SLOT_TSHI) | (slot == SLOT_TSLO);
  wire        win_wr_ok = slot_ok & sel_free & ~ts_slot
                          & ~(rx_win & (slot == SLOT_PRIO));
  wire        bad      = ~mapped | (slot_ok & ~sel_free)
                          | (pwrite & slot_ok & ~win_wr_ok);
  wire        wr_take  = psel & penable & pwrite & ~bad;
  wire        init_m   = ctrl_r[CTRL_INIT_BIT];
  wire        time_en  = ctrl_r[CTRL_TIME_BIT];

  // Register reads are captured in the setup cycle so that read data
  // comes from a flop and the access phase never waits.
  logic [7:0]  win_rd;
  logic [31:0] rd_val;
  assign win_rd = (slot == SLOT_ID2) ? 8'h00
                  : mem_r[wbuf][slot];
  assign rd_val = bad     ? 32'h0000_0000
                : slot_ok ? {24'h00_0000, win_rd}
                : is_ctrl ? {30'h0000_0000, ctrl_r}
                : is_flag ? {27'h000_0000, rxf_r, 1'b0, txe_r}
                : is_sel  ? {30'h0000_0000, sel_r}
                : {16'h0000, timer_r};
  assign pready = psel & penable;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr <= bad;
    end
  end

  // Bit-rate enable from a divider; the stamp timer only counts on it.
  wire bit_tick = (div_r == 16'(BIT_DIV - 1));
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_r <= 16'h0000;
    else if (bit_tick || init_m)
      div_r <= 16'h0000;
    else
      div_r <= div_r + 16'h0001;
  end

  // Wraps silently; software sees no overflow, by design.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_r <= '0;
    else if (init_m)
      timer_r <= '0;
    else if (bit_tick)
      timer_r <= timer_r + 1'b1;
  end

  // Internal prioritisation over every buffer still waiting to go.
  logic [NUM_TX-1:0] cand;
  logic [1:0]        win_idx;
  logic [7:0]        win_prio;
  logic              any_cand;
  assign cand     = ~txe_r;
  assign any_cand = |cand;
  always_comb
  begin
    win_idx  = 2'h0;
    win_prio = 8'hFF;
    for (int i = NUM_TX - 1; i >= 0; i--)
    begin
      // Scanning downward with <= lets the lower index win a tie.
      if (cand[i] && mem_r[i][SLOT_PRIO] <= win_prio)
      begin
        win_idx  = 2'(i);
        win_prio = mem_r[i][SLOT_PRIO];
      end
    end
  end

  // Frame length as streamed: header, length, then payload bytes.
  wire [7:0] act_id1 = mem_r[act_r][SLOT_ID1];
  wire [3:0] act_dl  = mem_r[act_r][SLOT_DLEN][3:0];
  wire [3:0] n_data  = act_id1[ID1_RTR_BIT] ? 4'h0
                     : (act_dl > DLEN_MAX) ? DLEN_MAX : act_dl;
  wire [3:0] n_total = n_data + 4'(HDR_BYTES);
  wire       start   = (st_r == TXS_IDLE) & sof_req & any_cand & ~init_m;

  // Byte order on the stream: identifier high byte first so that
  // bit ten leads, which lets the lowest value win on the wire.
  logic [7:0] src_byte;
  wire        src_valid = (st_r == TXS_SEND);
  logic       src_ready;
  assign src_byte = (pos_r == 4'h0) ? mem_r[act_r][SLOT_ID0]
                  : (pos_r == 4'h1) ? act_id1
                  : (pos_r == 4'h2) ? {4'h0, act_dl}
                  : mem_r[act_r][4'(pos_r + 4'h1)];
  wire        push = src_valid & src_ready;
  wire        last = push & (pos_r == n_total - 4'h1);

  cmb_fifo2 #(
    .WIDTH(8)
  ) u_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (src_valid),
    .in_ready  (src_ready),
    .in_data   (src_byte),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

  // Transmit sequencer; a lost arbitration or error returns to idle
  // with the buffer still pending so it competes again.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r     <= TXS_IDLE;
      act_r    <= 2'h0;
      pos_r    <= 4'h0;
      tx_start <= 1'b0;
    end
    else
    begin
      tx_start <= start;
      unique case (st_r)
        TXS_IDLE:
        begin
          if (start)
          begin
            act_r <= win_idx;
            pos_r <= 4'h0;
            st_r  <= TXS_SEND;
          end
        end
        TXS_SEND:
        begin
          if (last)
            st_r <= TXS_WAIT;
          else if (push)
            pos_r <= pos_r + 4'h1;
        end
        TXS_WAIT:
        begin
          if (tx_done || tx_abandon)
            st_r <= TXS_IDLE;
        end
        default:
          st_r <= TXS_IDLE;
      endcase
    end
  end

  wire tx_ok = (st_r == TXS_WAIT) & tx_done;

  // Control, select and flags. Hardware setting a flag beats a
  // software clear in the same cycle.
  wire [NUM_TX-1:0] txe_set = tx_ok ? NUM_TX'(1) << act_r : '0;
  wire [NUM_TX-1:0] txe_clr = (wr_take & is_flag) ? pwdata[NUM_TX-1:0]
                                                  : '0;
  wire              rxf_clr = wr_take & is_flag & pwdata[FLAG_RXF_BIT];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= CTRL_RST;
      sel_r  <= 2'h0;
      txe_r  <= TXE_RST;
      rxf_r  <= 1'b0;
    end
    else
    begin
      if (wr_take && is_ctrl)
        ctrl_r <= pwdata[1:0];
      if (wr_take && is_sel && pwdata[1:0] < 2'(NUM_TX))
        sel_r <= pwdata[1:0];
      txe_r <= (txe_r & ~txe_clr) | txe_set;
      rxf_r <= (rxf_r & ~rxf_clr) | rx_eof;
    end
  end

  // Buffer memory: software writes, received bytes and stamps.
  // Software cannot reach a pending buffer, but it can write buffer
  // three below the priority slot, where a received byte in the same cycle wins.
  always_ff @(posedge pclk)
  begin
    if (wr_take && slot_ok)
      mem_r[wbuf][slot] <= pwdata[7:0];
    if (rx_wr && rx_slot < SLOT_PRIO)
      mem_r[RXB][rx_slot] <= rx_byte;
    if (tx_ok && time_en)
    begin
      mem_r[act_r][SLOT_TSHI] <= timer_r[15:8];
      mem_r[act_r][SLOT_TSLO] <= timer_r[7:0];
    end
    if (rx_eof && time_en)
    begin
      mem_r[RXB][SLOT_TSHI] <= timer_r[15:8];
      mem_r[RXB][SLOT_TSLO] <= timer_r[7:0];
    end
  end

  // Checks on the behaviour above.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  timer_init_a: assert property (
    init_m |=> timer_r == '0)
    else $error("timer not cleared in init mode");

  timer_tick_a: assert property (
    !init_m && !$past(init_m) && bit_tick |=> timer_r == $past(timer_r) + 1'b1)
    else $error("timer did not advance on bit tick");

  timer_hold_a: assert property (
    !bit_tick && !init_m |=> $stable(timer_r))
    else $error("timer moved without a bit tick");

  prio_pick_a: assert property (
    start |-> cand[win_idx] &&
      (!cand[0] || mem_r[0][SLOT_PRIO] > win_prio || win_idx == 2'h0) &&
      (!cand[1] || mem_r[1][SLOT_PRIO] > win_prio || win_idx <= 2'h1) &&
      (!cand[2] || mem_r[2][SLOT_PRIO] >= win_prio))
    else $error("wrong transmit buffer chosen");

  first_byte_a: assert property (
    start |=> pos_r == 4'h0 && src_byte == mem_r[act_r][SLOT_ID0])
    else $error("identifier high byte not sent first");

  remote_len_a: assert property (
    push && act_id1[ID1_RTR_BIT] |-> pos_r < 4'(HDR_BYTES))
    else $error("remote frame carries data bytes");

  data_cnt_a: assert property (
    push |-> pos_r <= 4'(HDR_BYTES) + DLEN_MAX - 4'h1)
    else $error("payload longer than eight bytes");

  done_flag_a: assert property (
    tx_ok |=> txe_r[$past(act_r)] && st_r == TXS_IDLE)
    else $error("empty flag not set after transmit");

  stamp_a: assert property (
    tx_ok && time_en |=>
      {mem_r[$past(act_r)][SLOT_TSHI], mem_r[$past(act_r)][SLOT_TSLO]}
        == $past(timer_r))
    else $error("time stamp not written");

  ts_ro_a: assert property (
    psel && penable && pwrite && slot_ok && ts_slot |-> pslverr)
    else $error("stamp write not refused");

  cv_tx_frame: cover property (start ##[1:40] tx_ok);
  cv_stall: cover property (src_valid && !src_ready);
  cv_tie: cover property (start && cand == 3'h7);
  cv_rx_stamp: cover property (rx_eof && time_en);
endmodule

// ===== design/cmb_pkg.sv
// Package with the register map, field layout and timing of the buffers.
package cmb_pkg;
  // Byte slots of one message buffer inside the register window.
  localparam logic [3:0] SLOT_ID0   = 4'h0;
  localparam logic [3:0] SLOT_ID1   = 4'h1;
  localparam logic [3:0] SLOT_ID2   = 4'h2;
  localparam logic [3:0] SLOT_DLEN  = 4'h3;
  localparam logic [3:0] SLOT_DATA0 = 4'h4;
  localparam logic [3:0] SLOT_PRIO  = 4'hC;
  localparam logic [3:0] SLOT_TSHI  = 4'hD;
  localparam logic [3:0] SLOT_TSLO  = 4'hE;
  localparam int         NUM_SLOTS  = 15;
  // Register byte offsets; the window repeats per buffer.
  localparam logic [7:0] OFS_CTRL   = 8'h40;
  localparam logic [7:0] OFS_TXFLAG = 8'h44;
  localparam logic [7:0] OFS_TXSEL  = 8'h48;
  localparam logic [7:0] OFS_TIMER  = 8'h4C;
  localparam logic [7:0] OFS_RXWIN  = 8'h80;
  // Field positions.
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_TIME_BIT = 1;
  localparam int ID1_RTR_BIT   = 4;
  localparam int ID1_IDE_BIT   = 3;
  localparam int FLAG_RXF_BIT  = 4;
  // Reset values.
  localparam logic [1:0] CTRL_RST   = 2'h1;
  localparam logic [2:0] TXE_RST    = 3'h7;
  // Data length limits.
  localparam logic [3:0] DLEN_MAX   = 4'h8;
  localparam int         HDR_BYTES  = 3;
  // Timing: the stamp timer ticks once per nominal CAN bit.
  localparam int CLK_PERIOD_PS = 4000;
  localparam int BIT_TIME_PS   = 1000000;
  localparam int BIT_CYCLES    = BIT_TIME_PS / CLK_PERIOD_PS;
  // Transmit sequencer states.
  typedef enum logic [2:0] {
    TXS_IDLE = 3'b001,
    TXS_SEND = 3'b010,
    TXS_WAIT = 3'b100
  } cmb_txs_t;
endpackage

// ===== sim/cmb_buffers_tb.sv
// Self-checking bench for the CAN message buffers.
`timescale 1ns/100ps

module cmb_buffers_tb;
  import cmb_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, slow = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, tx_data, rx_byte = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, tx_start, tx_valid, tx_ready;
  logic        sof_req = 1'b0, tx_done = 1'b0, tx_abandon = 1'b0;
  logic        rx_wr = 1'b0, rx_eof = 1'b0;
  logic [3:0]  rx_slot = 4'h0;
  logic [15:0] t0, t1;
  logic [7:0]  id0 [3] = '{8'hA5, 8'h12, 8'h77};
  logic [7:0]  id1 [3] = '{8'h60, 8'h10, 8'hE8};
  logic [7:0]  dl  [3] = '{8'h03, 8'h05, 8'h00};
  logic [7:0]  pr  [3] = '{8'h05, 8'h05, 8'h02};
  int          fail_count = 0, total_checks = 0;
  int          starts = 0, quiet = 0;

  always #2 pclk = ~pclk;

  cmb_buffers #(.BIT_DIV(4)) cmb_buffers_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .sof_req(sof_req),
    .tx_start(tx_start), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_done(tx_done), .tx_abandon(tx_abandon),
    .rx_wr(rx_wr), .rx_slot(rx_slot), .rx_byte(rx_byte), .rx_eof(rx_eof));

  cmb_link_model cmb_link_model_i (
    .pclk(pclk), .presetn(presetn), .slow(slow), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));

  // Counts start pulses so that each frame request is seen to give one.
  always @(posedge pclk)
    if (tx_start === 1'b1)
      starts++;

  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic finish_test;
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge pclk);
    if (pready !== 1'b1)
    begin
      fail_count++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask

  // Single-cycle strobes towards the design: sof, done, abandon, eof.
  task automatic pulse(input int k);
    @(posedge pclk);
    case (k)
      0: sof_req <= 1'b1;
      1: tx_done <= 1'b1;
      2: tx_abandon <= 1'b1;
      default: rx_eof <= 1'b1;
    endcase
    @(posedge pclk);
    {sof_req, tx_done, tx_abandon, rx_eof} <= 4'h0;
  endtask

  // Requests a frame and compares every byte the link accepted.
  task automatic txf(input logic [7:0] e [$]);
    int n;
    int s0;
    s0 = starts;
    pulse(0);
    for (n = 0; n < 300 && cmb_link_model_i.got.size() < e.size(); n++)
      @(posedge pclk);
    repeat (20) @(posedge pclk);
    chk("start pulse", starts - s0, 1);
    chk("frame length", cmb_link_model_i.got.size(), e.size());
    foreach (e[i])
      chk("frame byte", cmb_link_model_i.got[i], e[i]);
    cmb_link_model_i.got.delete();
  endtask

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc("tx flags", OFS_TXFLAG, 32'h07);
    rdc("ctrl", OFS_CTRL, 32'h01);
    rdc("timer init", OFS_TIMER, 32'h0);
    apb(1'b0, 8'h50, 32'h0);
    chk("unmapped", err, 1'b1);
    for (int b = 0; b < 3; b++)
    begin
      wr(OFS_TXSEL, b);
      wr(8'h00, id0[b]);
      wr(8'h04, id1[b]);
      wr(8'h0C, dl[b]);
      wr(8'h30, pr[b]);
      for (int k = 0; k < 8; k++)
        wr(8'h10 + 8'(4 * k), 8'h11 * (k + 1));
    end
    rdc("id byte2", 8'h08, 32'h0);
    rdc("priority", 8'h30, 32'h02);
    wr(8'h34, 32'h5A);
    chk("stamp write", err, 1'b1);
    wr(OFS_CTRL, 32'h2);
    wr(OFS_TXFLAG, 32'h7);
    apb(1'b0, 8'h30, 32'h0);
    chk("busy prio", err, 1'b1);
    slow <= 1'b1;
    txf('{8'h77, 8'hE8, 8'h00});
    slow <= 1'b0;
    pulse(1);
    rdc("tx flags", OFS_TXFLAG, 32'h04);
    wr(OFS_TXSEL, 32'h2);
    apb(1'b0, 8'h34, 32'h0);
    t0[15:8] = rd[7:0];
    apb(1'b0, 8'h38, 32'h0);
    t0[7:0] = rd[7:0];
    apb(1'b0, OFS_TIMER, 32'h0);
    t1 = rd[15:0];
    chk("stamp age", (t1 - t0) < 16'h10, 1'b1);
    txf('{8'hA5, 8'h60, 8'h03, 8'h11, 8'h22, 8'h33});
    pulse(2);
    rdc("tx flags", OFS_TXFLAG, 32'h04);
    txf('{8'hA5, 8'h60, 8'h03, 8'h11, 8'h22, 8'h33});
    pulse(1);
    rdc("tx flags", OFS_TXFLAG, 32'h05);
    txf('{8'h12, 8'h10, 8'h05});
    pulse(1);
    rdc("tx flags", OFS_TXFLAG, 32'h07);
    quiet = starts;
    pulse(0);
    repeat (10) @(posedge pclk);
    chk("no frame", cmb_link_model_i.got.size(), 0);
    chk("no start", starts - quiet, 0);
    // A length code above eight still sends only eight data bytes.
    wr(OFS_TXSEL, 32'h2);
    wr(8'h0C, 32'h0F);
    wr(OFS_TXFLAG, 32'h4);
    txf('{8'h77, 8'hE8, 8'h0F, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55,
          8'h66, 8'h77, 8'h88});
    pulse(1);
    rdc("tx flags", OFS_TXFLAG, 32'h07);
    @(posedge pclk);
    rx_wr <= 1'b1;
    rx_slot <= 4'h1;
    rx_byte <= 8'h3C;
    @(posedge pclk);
    rx_wr <= 1'b0;
    pulse(3);
    rdc("rx id1", 8'h84, 32'h3C);
    rdc("rx full", OFS_TXFLAG, 32'h17);
    wr(8'hB0, 32'h1);
    chk("rx prio", err, 1'b1);
    apb(1'b0, OFS_TIMER, 32'h0);
    t0 = rd[15:0];
    repeat (40) @(posedge pclk);
    apb(1'b0, OFS_TIMER, 32'h0);
    t1 = rd[15:0] - t0;
    chk("timer rate", t1 >= 16'hA && t1 <= 16'hB, 1'b1);
    wr(OFS_CTRL, 32'h1);
    rdc("timer cleared", OFS_TIMER, 32'h0);
    finish_test();
  end

  // A hang anywhere ends the run as a failure.
  initial
  begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    finish_test();
  end
endmodule

// ===== sim/cmb_link_model.sv
// Link-side partner that takes transmit bytes, with optional stalls.
`timescale 1ns/100ps

module cmb_link_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic       phase_r;
  logic [7:0] got [$];

  // Slow mode accepts on every other cycle, so the buffer must hold a byte.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      phase_r <= 1'b0;
    else
      phase_r <= ~phase_r;

  assign tx_ready = presetn && (!slow || phase_r);

  // Every accepted byte is logged in order for the bench to compare.
  always @(posedge pclk)
    if (presetn && tx_valid && tx_ready)
      got.push_back(tx_data);
endmodule
